// file: hdl/sisw_pkg.sv
// Package of constants for the switch configuration loader
package sisw_pkg;
    localparam int SW_W       = 8;
    localparam int CFG_W      = 16;
    localparam int SW_VSEL_LO = 0;
    localparam int SW_VSEL_HI = 1;
    localparam int SW_DIAG_LO = 2;
    localparam int SW_DIAG_HI = 3;
    localparam int SW_HOLD    = 4;
    localparam int SW_MEM     = 5;
    localparam int OUT_W      = 32;
    // Edges spent filling the pin synchronisers before the one-time sample
    localparam logic [1:0] SYNC_WAIT = 2'h3;
    localparam logic [2:0] BYTES_4 = 3'h4;
    localparam logic [2:0] BYTES_3 = 3'h3;
    localparam logic [2:0] BYTES_2 = 3'h2;
    localparam logic [2:0] BYTES_1 = 3'h1;
    localparam logic [1:0] DIAG_M0 = 2'h0;
    localparam logic [1:0] DIAG_M1 = 2'h1;
    localparam logic [1:0] DIAG_M2 = 2'h2;
    localparam logic [2:0] DIAG_B0 = 3'h0;
    localparam logic [2:0] DIAG_B4 = 3'h4;
    localparam logic [2:0] DIAG_B6 = 3'h6;
    localparam logic [31:0] OUT_OFF = 32'h0000_0000;
    localparam logic [CFG_W-1:0] CFG_RST = 16'h0000;
    // Fieldbus states seen by the output policy
    localparam logic [3:0] FB_INIT   = 4'h1;
    localparam logic [3:0] FB_PREOP  = 4'h2;
    localparam logic [3:0] FB_SAFEOP = 4'h4;
    localparam logic [3:0] FB_OP     = 4'h8;
    typedef enum logic [3:0] {
        LD_IDLE = 4'h1,
        LD_SAMP = 4'h2,
        LD_MEM  = 4'h4,
        LD_DONE = 4'h8
    } sisw_ld_e;
endpackage

// file: hdl/sisw_out_policy.sv
// Valve output policy on communication error or idle
`timescale 1ns/1ns
module sisw_out_policy (
    input  wire logic                    clk,
    input  wire logic                    nrst,
    input  wire logic                    cfg_valid,
    input  wire logic                    hold_sel,
    input  wire logic [2:0]              out_bytes,
    input  wire logic [3:0]              fb_state,
    input  wire logic                    comm_err,
    input  wire logic [sisw_pkg::OUT_W-1:0] out_data,
    output logic      [sisw_pkg::OUT_W-1:0] valve_out
);
    import sisw_pkg::*;

    logic [OUT_W-1:0] valve_q;
    logic [OUT_W-1:0] valve_d;
    logic [OUT_W-1:0] size_mask;
    logic             idle;
    logic             fault;

    // Only operational counts as running; anything else is idle
    assign idle  = (fb_state == FB_INIT) || (fb_state == FB_PREOP)
                || (fb_state == FB_SAFEOP) || (fb_state != FB_OP);
    assign fault = idle || comm_err || !cfg_valid;
    assign size_mask = (out_bytes == BYTES_1) ? 32'h0000_00FF :
                       (out_bytes == BYTES_2) ? 32'h0000_FFFF :
                       (out_bytes == BYTES_3) ? 32'h00FF_FFFF : 32'hFFFF_FFFF;
    assign valve_d = !fault ? (out_data & size_mask) :
                     (hold_sel && cfg_valid) ? valve_q : OUT_OFF;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            valve_q <= OUT_OFF;
        end else begin
            valve_q <= valve_d;
        end
    end
    assign valve_out = valve_q;

    policy_clear_a: assert property (@(posedge clk) disable iff (!nrst)
        (fault && !hold_sel) |=> (valve_out == OUT_OFF))
        else $error("outputs not cleared on fault");
    policy_hold_a: assert property (@(posedge clk) disable iff (!nrst)
        (fault && hold_sel && cfg_valid) |=> $stable(valve_out))
        else $error("outputs not held on fault");
    policy_idle_a: assert property (@(posedge clk) disable iff (!nrst)
        (fb_state == FB_PREOP && !hold_sel) |=> (valve_out == OUT_OFF))
        else $error("idle state drove outputs");
    policy_size_a: assert property (@(posedge clk) disable iff (!nrst)
        (!fault && out_bytes == BYTES_1) |=> (valve_out[31:8] == 24'h000000))
        else $error("output size not applied");
endmodule // sisw_out_policy

// file: hdl/sisw_switch_config.sv
// Top of the power-up switch configuration loader
//
// Overview of operation
// - Switches 1,2 pick 4/3/2/1 output bytes
// - Switches 3,4 pick diag mode 0/1/2
// - Switch 5: clear or hold outputs on fault
// - Init, preop, safeop states count as idle
// - Interrupted communication is error; policy persists
// - Switch 6 on: compare memory, flag mismatch
// - Switch 6 off: store present manifold layout
// - Sample switches only at power-up
// - All switches default to off
// - Switches 7 and 8 ignored
`timescale 1ns/1ns
module sisw_switch_config (
    input  wire logic                          clk,
    input  wire logic                          nrst,
    input  wire logic [sisw_pkg::SW_W-1:0]     sw_in,
    input  wire logic [sisw_pkg::CFG_W-1:0]    manifold_cfg,
    input  wire logic [3:0]                    fb_state,
    input  wire logic                          comm_err,
    input  wire logic [sisw_pkg::OUT_W-1:0]    out_data,
    output logic      [sisw_pkg::OUT_W-1:0]    valve_out,
    output logic      [2:0]                    out_bytes,
    output logic      [1:0]                    diag_mode,
    output logic      [2:0]                    diag_bytes,
    output logic                               hold_sel,
    output logic                               mem_mode,
    output logic                               cfg_valid,
    output logic                               cfg_mismatch,
    output logic                               mem_wr,
    output logic      [sisw_pkg::CFG_W-1:0]    mem_wdata
);
    import sisw_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Decoding functions
    function automatic logic [2:0] vsel_bytes(input logic [1:0] s);
        case (s)
            2'h0: vsel_bytes = BYTES_4;
            2'h1: vsel_bytes = BYTES_3;
            2'h2: vsel_bytes = BYTES_2;
            default: vsel_bytes = BYTES_1;
        endcase
    endfunction

    function automatic logic [1:0] diag_of(input logic [1:0] s);
        case (s)
            2'h0: diag_of = DIAG_M0;
            2'h1: diag_of = DIAG_M1;
            default: diag_of = DIAG_M2;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Synchronisers for switch pins and manifold sense lines
    logic [SW_W-1:0]  sw_m_q;
    logic [SW_W-1:0]  sw_s_q;
    logic [CFG_W-1:0] mf_m_q;
    logic [CFG_W-1:0] mf_s_q;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            sw_m_q <= '0;
            sw_s_q <= '0;
            mf_m_q <= CFG_RST;
            mf_s_q <= CFG_RST;
        end else begin
            sw_m_q <= sw_in;
            sw_s_q <= sw_m_q;
            mf_m_q <= manifold_cfg;
            mf_s_q <= mf_m_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Load sequence: wait for synchroniser to fill, sample once, then freeze
    sisw_ld_e         st_q;
    sisw_ld_e         st_d;
    logic [1:0]       ver_q;
    logic [1:0]       ver_d;
    logic [CFG_W-1:0] store_q;
    logic             store_vld_q;
    logic [2:0]       ob_q;
    logic [1:0]       dm_q;
    logic [2:0]       db_q;
    logic             hs_q;
    logic             mm_q;
    logic             mis_q;
    logic             mw_q;
    logic             cv_q;
    logic             sample;
    logic             compare;
    logic [1:0]       dm_new;

    // Four idle cycles before the sample; both synchroniser stages hold real pin levels by then
    assign ver_d  = (st_q == LD_IDLE) ? ver_q + 2'h1 : ver_q;
    assign sample = (st_q == LD_SAMP);
    assign dm_new = diag_of({sw_s_q[SW_DIAG_LO], sw_s_q[SW_DIAG_HI]});
    // Memory lives in a retained register; content kept across reset
    assign compare = sample && sw_s_q[SW_MEM] && store_vld_q;

    always_comb begin
        st_d = st_q;
        case (st_q)
            LD_IDLE: if (ver_q == SYNC_WAIT) st_d = LD_SAMP;
            LD_SAMP: st_d = LD_MEM;
            LD_MEM:  st_d = LD_DONE;
            LD_DONE: st_d = LD_DONE;
            default: st_d = LD_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_q  <= LD_IDLE;
            ver_q <= 2'h0;
            cv_q  <= 1'b0;
        end else begin
            st_q  <= st_d;
            ver_q <= ver_d;
            // Registered so the valid flag leaves the block glitch-free
            cv_q  <= sample || cv_q;
        end
    end

    // Switches 7 and 8 are never read
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ob_q  <= BYTES_4;
            dm_q  <= DIAG_M0;
            db_q  <= DIAG_B0;
            hs_q  <= 1'b0;
            mm_q  <= 1'b0;
            mis_q <= 1'b0;
            mw_q  <= 1'b0;
        end else begin
            mw_q <= sample && !sw_s_q[SW_MEM];
            if (sample) begin
                ob_q <= vsel_bytes({sw_s_q[SW_VSEL_LO], sw_s_q[SW_VSEL_HI]});
                dm_q <= dm_new;
                db_q <= (dm_new == DIAG_M0) ? DIAG_B0 :
                        (dm_new == DIAG_M1) ? DIAG_B4 : DIAG_B6;
                hs_q <= sw_s_q[SW_HOLD];
                mm_q <= sw_s_q[SW_MEM];
            end
            if (compare && (store_q != mf_s_q)) begin
                mis_q <= 1'b1;
            end
        end
    end

    // Configuration memory: written on power-up in normal mode only
    always_ff @(posedge clk) begin
        if (sample && !sw_s_q[SW_MEM]) begin
            store_q     <= mf_s_q;
            store_vld_q <= 1'b1;
        end else if (store_vld_q !== 1'b1) begin
            store_q     <= CFG_RST;
            store_vld_q <= 1'b0;
        end
    end

    assign out_bytes    = ob_q;
    assign diag_mode    = dm_q;
    assign diag_bytes   = db_q;
    assign hold_sel     = hs_q;
    assign mem_mode     = mm_q;
    assign cfg_valid    = cv_q;
    assign cfg_mismatch = mis_q;
    assign mem_wr       = mw_q;
    assign mem_wdata    = store_q;

    ////////////////////////////////////////////////////////////////////////////
    // Output stage
    sisw_out_policy u_pol (
        .clk       (clk),
        .nrst      (nrst),
        .cfg_valid (cfg_valid),
        .hold_sel  (hs_q),
        .out_bytes (ob_q),
        .fb_state  (fb_state),
        .comm_err  (comm_err),
        .out_data  (out_data),
        .valve_out (valve_out)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_loaded;
        st_q == LD_DONE;
    endsequence

    cfg_frozen_a: assert property (@(posedge clk) disable iff (!nrst)
        s_loaded |=> ($stable(ob_q) && $stable(dm_q) && $stable(hs_q)))
        else $error("configuration changed after load");
    vsel_dec_a: assert property (@(posedge clk) disable iff (!nrst)
        (sample && sw_s_q[1:0] == 2'h0) |=> (ob_q == BYTES_4))
        else $error("default output size wrong");
    diag_dec_a: assert property (@(posedge clk) disable iff (!nrst)
        (sample && sw_s_q[3:2] == 2'h3) |=> (db_q == DIAG_B6))
        else $error("diagnostic size wrong");
    mis_sticky_a: assert property (@(posedge clk) disable iff (!nrst)
        mis_q |=> mis_q)
        else $error("mismatch flag dropped");
    mem_store_a: assert property (@(posedge clk) disable iff (!nrst)
        (sample && !sw_s_q[SW_MEM]) |=> (mw_q && !mis_q))
        else $error("normal mode did not store");
    sw78_a: assert property (@(posedge clk) disable iff (!nrst)
        sample |=> ((hs_q == $past(sw_s_q[SW_HOLD])) && (mm_q == $past(sw_s_q[SW_MEM]))
            && (ob_q == vsel_bytes({$past(sw_s_q[SW_VSEL_LO]), $past(sw_s_q[SW_VSEL_HI])}))))
        else $error("configuration not taken from switches 1 to 6");
    mis_cmp_a: assert property (@(posedge clk) disable iff (!nrst)
        (compare && store_q != mf_s_q) |=> cfg_mismatch)
        else $error("mismatch not flagged");
    load_time_a: assert property (@(posedge clk) disable iff (!nrst)
        (st_q == LD_IDLE && ver_q == 2'h0) |-> ##[1:6] cfg_valid)
        else $error("configuration not loaded in time");
endmodule // sisw_switch_config

// file: testbench/sisw_master_model.sv
// Upstream fieldbus master model: state, error and valve data
`timescale 1ns/1ns
module sisw_master_model (
    input  wire logic                        clk,
    input  wire logic [3:0]                  st_req,
    input  wire logic                        err_req,
    input  wire logic [sisw_pkg::OUT_W-1:0]  dat_req,
    output logic      [3:0]                  fb_state,
    output logic                             comm_err,
    output logic      [sisw_pkg::OUT_W-1:0]  out_data
);
    import sisw_pkg::*;
    // Master sits on the upstream port; updates land off the sampling edge
    always @(negedge clk) begin
        fb_state <= st_req;
        comm_err <= err_req;
        out_data <= dat_req;
    end
endmodule // sisw_master_model

// file: testbench/si_unit_switch_config_tb.sv
// Self-checking bench for the switch configuration loader
`timescale 1ns/1ns
module si_unit_switch_config_tb;
    import sisw_pkg::*;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [7:0]  sw_in = 8'h00;
    logic [15:0] manifold_cfg = 16'h0000;
    logic [3:0]  st_req = FB_INIT;
    logic        err_req = 1'b0;
    logic [31:0] dat_req = 32'h0000_0000;
    logic [3:0]  fb_state;
    logic        comm_err;
    logic [31:0] out_data, valve_out;
    logic [2:0]  out_bytes, diag_bytes;
    logic [1:0]  diag_mode;
    logic        hold_sel, mem_mode, cfg_valid, cfg_mismatch, mem_wr;
    logic [15:0] mem_wdata, wr_data;
    logic        wr_seen;
    int          n_mismatch = 0;
    int          num_checks = 0;
    ////////////////////////////////////////////////////////////////////////////
    sisw_master_model mst (.clk(clk), .st_req(st_req), .err_req(err_req),
        .dat_req(dat_req), .fb_state(fb_state), .comm_err(comm_err), .out_data(out_data));
    sisw_switch_config dut (.clk(clk), .nrst(nrst), .sw_in(sw_in),
        .manifold_cfg(manifold_cfg), .fb_state(fb_state), .comm_err(comm_err),
        .out_data(out_data), .valve_out(valve_out), .out_bytes(out_bytes),
        .diag_mode(diag_mode), .diag_bytes(diag_bytes), .hold_sel(hold_sel),
        .mem_mode(mem_mode), .cfg_valid(cfg_valid), .cfg_mismatch(cfg_mismatch),
        .mem_wr(mem_wr), .mem_wdata(mem_wdata));
    initial begin
        forever #20 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // Power cycle: switches and layout set before release, store pulse recorded
    task automatic pwr_up(input logic [7:0] sw, input logic [15:0] mcfg);
        @(negedge clk);
        nrst = 1'b0;
        sw_in = sw;
        manifold_cfg = mcfg;
        repeat (16) @(negedge clk);
        nrst = 1'b1;
        wr_seen = 1'b0;
        repeat (20) begin
            @(negedge clk);
            if (mem_wr === 1'b1) begin
                wr_seen = 1'b1;
                wr_data = mem_wdata;
            end
        end
        chk(cfg_valid, 1);
    endtask
    task automatic t_decode();
        logic [1:0] i;
        for (int k = 0; k < 4; k++) begin
            i = k[1:0];
            // Switches 7,8 walk too and must change nothing
            pwr_up({i, 2'b00, i[0], i[1], i[0], i[1]}, 16'h0000);
            chk(out_bytes, 3'h4 - 3'(k));
            chk(diag_mode, (k == 0) ? DIAG_M0 : (k == 1) ? DIAG_M1 : DIAG_M2);
            chk(diag_bytes, (k == 0) ? DIAG_B0 : (k == 1) ? DIAG_B4 : DIAG_B6);
            // Running with all data bits set shows the selected output width
            st_req = FB_OP;
            dat_req = 32'hFFFF_FFFF;
            repeat (4) @(negedge clk);
            chk(valve_out, 32'hFFFF_FFFF >> (8 * k));
            st_req = FB_INIT;
        end
    endtask
    task automatic t_defaults_latch();
        pwr_up(8'h00, 16'h0000);
        chk({out_bytes, diag_mode, hold_sel, mem_mode}, {BYTES_4, DIAG_M0, 2'b00});
        chk(cfg_mismatch, 0);
        sw_in = 8'h3F;
        repeat (12) @(negedge clk);
        chk({out_bytes, diag_bytes, hold_sel, mem_mode}, {BYTES_4, DIAG_B0, 2'b00});
    endtask
    task automatic t_memory();
        pwr_up(8'h00, 16'h1234);
        chk(wr_seen, 1);
        chk(wr_data, 16'h1234);
        pwr_up(8'h20, 16'h1234);
        chk({mem_mode, cfg_mismatch, wr_seen}, 3'b100);
        pwr_up(8'h20, 16'h1235);
        chk({mem_mode, cfg_mismatch}, 2'b11);
        manifold_cfg = 16'h1234;
        repeat (12) @(negedge clk);
        chk(cfg_mismatch, 1);
    endtask
    // Full 4-byte size so all 32 valves are covered by the selection
    task automatic t_policy(input logic hold);
        logic [3:0] idle [3] = '{FB_INIT, FB_PREOP, FB_SAFEOP};
        logic [31:0] d;
        pwr_up({3'h0, hold, 4'h0}, 16'h0000);
        chk(hold_sel, hold);
        for (int k = 0; k < 4; k++) begin
            d = 32'hA5C3_0F10 + 32'(k);
            st_req = FB_OP;
            err_req = 1'b0;
            dat_req = d;
            repeat (4) @(negedge clk);
            chk(valve_out, d);
            dat_req = ~d;
            if (k < 3) st_req = idle[k];
            else err_req = 1'b1;
            repeat (6) @(negedge clk);
            chk(valve_out, hold ? d : OUT_OFF);
        end
        err_req = 1'b0;
        st_req = FB_INIT;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        summarize();
    end
    initial begin
        t_defaults_latch();
        t_decode();
        t_memory();
        t_policy(1'b0);
        t_policy(1'b1);
        summarize();
    end
endmodule // si_unit_switch_config_tb
